// File: common/twi_regs.svh
// Timing and field constants for the two-wire bus engine
// Summary of operation
// - One bit per clock, data stable while high.
// - Data change mid-byte while clock high aborts.
// - Transmitter changes data only while clock low.
// - Transaction is start, bytes, then stop.
// - Bytes go MSB first, then acknowledge slot.
// - Slave may stretch clock low; master waits.
// - Master starts, clocks and ends transactions.
// - Master and slave roles fixed per transaction.
// - Bus busy from start until after stop.
// - Start is data falling while clock high.
// - Stop is data rising while clock high.
// - Master may issue repeated start without stop.
// - Master gives ninth clock for acknowledge.
// - Transmitter releases data during acknowledge clock.
// - Receiver acknowledges by holding data low.
// - Master receiver leaves last byte unacknowledged.
// - Full or busy receiver answers negative acknowledge; a full receive FIFO here holds clock low until space, then acknowledges.
// - Start detected in power-down raises wake-up.
// - Seven address bits, then direction, 1 reads.
// - Master aborts when sampled data differs.
// - Losing master drops to slave, keeps listening.
`ifndef TWI_REGS_SVH
`define TWI_REGS_SVH
`define TWI_CLK_NS     10
`define TWI_T_QTR_NS   2500
`define TWI_QTR_CYC    ((`TWI_T_QTR_NS + `TWI_CLK_NS - 1) / `TWI_CLK_NS)
`define TWI_T_BUF_NS   4700
`define TWI_BUF_CYC    ((`TWI_T_BUF_NS + `TWI_CLK_NS - 1) / `TWI_CLK_NS)
`define TWI_ACK_BIT    4'h8
`define TWI_FIFO_DEPTH 4
`define TWI_BYTE_W     8
`endif

// File: common/twi_pkg.sv
// Types shared by the two-wire bus engine
package twi_pkg;
  typedef enum logic [2:0] {M_IDLE = 3'h0, M_START = 3'h1, M_HOLD = 3'h2, M_LO = 3'h3,
                            M_REL = 3'h4, M_HI = 3'h5, M_COND = 3'h6} twi_mst_e;
  typedef enum logic [1:0] {S_IDLE = 2'h0, S_SHIFT = 2'h1, S_ACK = 2'h2, S_HOLD = 2'h3} twi_slv_e;
  typedef enum logic [1:0] {OP_START = 2'h0, OP_WRITE = 2'h1, OP_READ = 2'h2, OP_STOP = 2'h3} twi_op_e;
  typedef struct packed {
    twi_op_e    op;
    logic [7:0] data;
    logic       last;
  } twi_cmd_s;
  typedef struct packed {
    logic busy;
    logic master;
    logic arb_lost;
    logic bus_err;
    logic nack;
  } twi_stat_s;
  typedef struct packed {
    twi_mst_e   st;
    logic [8:0] cnt;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic       rd;
    logic       last;
    logic       stp;
    logic       scl_lo;
    logic       sda_lo;
    logic       master;
    logic       arb;
    logic       err;
    logic       nack;
    logic       push;
  } twi_mst_s;
  typedef struct packed {
    twi_slv_e   st;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic       ad;
    logic       scl_lo;
    logic       sda_lo;
    logic       push;
  } twi_slv_s;
endpackage

// File: verilog/twi_engine.sv
// Two-wire bus protocol engine with receive FIFO
`timescale 1ns/10ps
`default_nettype none
`include "twi_regs.svh"

module twi_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0]   cnt, next_cnt;
  logic          wr, rd;

  // Pointer and count update
  always_comb begin
    wr = in_valid && in_ready;
    rd = out_valid && out_ready;
    next_wp = wr ? AW'(wp + 1'b1) : wp;
    next_rp = rd ? AW'(rp + 1'b1) : rp;
    next_cnt = (AW+1)'(cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd});
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wp] <= in_data;
    end
  end

  assign in_ready  = cnt != (AW+1)'(D);
  assign out_valid = cnt != '0;
  assign out_data  = mem[rp];
endmodule

module twi_engine
  import twi_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Bus pins, open-drain
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Command port
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire twi_cmd_s   cmd,
  // Received byte stream
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  // Configuration and status
  input  wire logic [6:0] own_addr,
  input  wire logic       slave_en,
  input  wire logic       pd_mode,
  output logic            wake,
  output twi_stat_s       stat
);
  localparam logic [8:0] QTR_END = 9'(`TWI_QTR_CYC - 1);
  localparam logic [8:0] BUF_END = 9'(`TWI_BUF_CYC - 1);

  logic [2:0] scl_sy, sda_sy;
  logic       scl_f, sda_f, scl_d, sda_d;
  logic       next_scl_f, next_sda_f;
  logic       scl_rise, scl_fall, start_det, stop_det;
  logic       busy, next_busy, free_arm, next_free_arm;
  logic [8:0] free_cnt, next_free_cnt;
  logic       next_wake;
  twi_mst_s   m, nm;
  twi_slv_s   s, ns;
  logic       run, tick, take, fifo_rdy;
  logic       in_valid;
  logic [7:0] in_data;

  // Pin filter: change accepted once stages two and three agree
  always_comb begin
    next_scl_f = (scl_sy[1] == scl_sy[2]) ? scl_sy[2] : scl_f;
    next_sda_f = (sda_sy[1] == sda_sy[2]) ? sda_sy[2] : sda_f;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
      scl_f  <= 1'b1;
      sda_f  <= 1'b1;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[1:0], scl_in};
      sda_sy <= {sda_sy[1:0], sda_in};
      scl_f  <= next_scl_f;
      sda_f  <= next_sda_f;
      scl_d  <= scl_f;
      sda_d  <= sda_f;
    end
  end

  // Bus condition detection
  assign scl_rise  = scl_f && !scl_d;
  assign scl_fall  = !scl_f && scl_d;
  assign start_det = scl_f && scl_d && !sda_f && sda_d;
  assign stop_det  = scl_f && scl_d && sda_f && !sda_d;

  // Busy from start until bus-free time after stop
  always_comb begin
    next_busy     = busy;
    next_free_arm = free_arm;
    next_free_cnt = free_cnt;
    if (start_det) begin
      next_busy     = 1'b1;
      next_free_arm = 1'b0;
    end else if (stop_det) begin
      next_free_arm = 1'b1;
      next_free_cnt = '0;
    end else if (free_arm) begin
      if (free_cnt == BUF_END) begin
        next_busy     = 1'b0;
        next_free_arm = 1'b0;
      end else begin
        next_free_cnt = 9'(free_cnt + 1'b1);
      end
    end
    next_wake = pd_mode && start_det;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy     <= 1'b0;
      free_arm <= 1'b0;
      free_cnt <= '0;
      wake     <= 1'b0;
    end else begin
      busy     <= next_busy;
      free_arm <= next_free_arm;
      free_cnt <= next_free_cnt;
      wake     <= next_wake;
    end
  end

  // Quarter-bit timer halts while a released clock is held low
  assign run       = m.scl_lo || scl_f;
  assign tick      = run && (m.cnt == QTR_END);
  assign cmd_ready = (m.st == M_IDLE && !(cmd.op == OP_START && busy)) || m.st == M_HOLD;
  assign take      = cmd_valid && cmd_ready;

  // Master sequencer
  always_comb begin
    nm = m;
    nm.push = 1'b0;
    nm.cnt = tick ? '0 : (run ? 9'(m.cnt + 1'b1) : m.cnt);
    case (m.st)
      M_IDLE: begin
        if (take && cmd.op == OP_START) begin
          nm.sda_lo = 1'b1;
          nm.st     = M_START;
          nm.cnt    = '0;
          nm.arb    = 1'b0;
          nm.err    = 1'b0;
          nm.nack   = 1'b0;
        end
      end
      M_START: begin
        if (tick) begin
          nm.scl_lo = 1'b1;
          nm.master = 1'b1;
          nm.st     = M_HOLD;
        end
      end
      M_HOLD: begin
        if (take) begin
          nm.cnt  = '0;
          nm.bitn = '0;
          nm.arb  = 1'b0;
          nm.err  = 1'b0;
          nm.nack = 1'b0;
          nm.ph   = 2'h0;
          nm.stp  = cmd.op == OP_STOP;
          nm.rd   = cmd.op == OP_READ;
          nm.last = cmd.last;
          nm.sh   = cmd.data;
          nm.st   = (cmd.op == OP_START || cmd.op == OP_STOP) ? M_COND : M_LO;
        end
      end
      M_LO: begin
        if (tick && !(m.bitn == `TWI_ACK_BIT && m.rd && !fifo_rdy)) begin
          nm.push   = m.bitn == `TWI_ACK_BIT && m.rd;
          nm.sda_lo = (m.bitn == `TWI_ACK_BIT) ? (m.rd && !m.last) : (!m.rd && !m.sh[7]);
          nm.st     = M_REL;
        end
      end
      M_REL: begin
        if (tick) begin
          nm.scl_lo = 1'b0;
          nm.st     = M_HI;
        end
      end
      M_HI: begin
        if (tick) begin
          if (!m.rd && m.bitn != `TWI_ACK_BIT && !m.sda_lo && !sda_f) begin
            nm.scl_lo = 1'b0;
            nm.sda_lo = 1'b0;
            nm.master = 1'b0;
            nm.arb    = 1'b1;
            nm.st     = M_IDLE;
          end else begin
            nm.scl_lo = 1'b1;
            nm.sh     = {m.sh[6:0], sda_f};
            if (m.bitn == `TWI_ACK_BIT) begin
              nm.st = M_HOLD;
              if (!m.rd) begin
                nm.nack = sda_f;
              end
            end else begin
              nm.bitn = 4'(m.bitn + 1'b1);
              nm.st   = M_LO;
            end
          end
        end
      end
      M_COND: begin
        if (tick) begin
          nm.ph = 2'(m.ph + 1'b1);
          case (m.ph)
            2'h0: nm.sda_lo = m.stp;
            2'h1: nm.scl_lo = 1'b0;
            default: begin
              nm.sda_lo = !m.stp;
              nm.master = !m.stp;
              nm.st     = m.stp ? M_IDLE : M_START;
            end
          endcase
        end
      end
      default: nm.st = M_IDLE;
    endcase
    if ((m.st == M_LO || m.st == M_REL || m.st == M_HI) && (start_det || stop_det)) begin
      nm.scl_lo = 1'b0;
      nm.sda_lo = 1'b0;
      nm.master = 1'b0;
      nm.err    = 1'b1;
      nm.push   = 1'b0;
      nm.st     = M_IDLE;
    end
  end

  // Slave receiver: address match, acknowledge, stretch on full FIFO
  always_comb begin
    ns = s;
    ns.push = 1'b0;
    if (start_det) begin
      ns.st     = S_SHIFT;
      ns.bitn   = '0;
      ns.ad     = 1'b1;
      ns.scl_lo = 1'b0;
      ns.sda_lo = 1'b0;
    end else if (stop_det) begin
      ns.st     = S_IDLE;
      ns.scl_lo = 1'b0;
      ns.sda_lo = 1'b0;
    end else begin
      case (s.st)
        S_SHIFT: begin
          if (scl_rise && s.bitn != `TWI_ACK_BIT) begin
            ns.sh   = {s.sh[6:0], sda_f};
            ns.bitn = 4'(s.bitn + 1'b1);
          end else if (scl_fall && s.bitn == `TWI_ACK_BIT) begin
            if (!s.ad) begin
              ns.sda_lo = 1'b1;
              ns.scl_lo = 1'b1;
              ns.st     = S_HOLD;
            end else if (s.sh[7:1] == own_addr && !s.sh[0] && slave_en && !m.master) begin
              ns.sda_lo = 1'b1;
              ns.st     = S_ACK;
            end else begin
              ns.st = S_IDLE;
            end
          end
        end
        S_HOLD: begin
          if (fifo_rdy && !m.push) begin
            ns.push   = 1'b1;
            ns.scl_lo = 1'b0;
            ns.st     = S_ACK;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            ns.sda_lo = 1'b0;
            ns.bitn   = '0;
            ns.ad     = 1'b0;
            ns.st     = S_SHIFT;
          end
        end
        default: ns.st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      m <= '{st: M_IDLE, default: '0};
      s <= '{st: S_IDLE, default: '0};
    end else begin
      m <= nm;
      s <= ns;
    end
  end

  // Receive byte buffer
  assign in_valid = m.push || s.push;
  assign in_data  = m.push ? m.sh : s.sh;

  twi_fifo #(.W(`TWI_BYTE_W), .D(`TWI_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (in_valid),
    .in_ready  (fifo_rdy),
    .in_data   (in_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // Open-drain drive, never high
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = m.scl_lo || s.scl_lo;
  assign sda_oe  = m.sda_lo || s.sda_lo;
  assign stat    = '{busy: busy, master: m.master, arb_lost: m.arb, bus_err: m.err, nack: m.nack};

  // Checks
  chk_sda_stable_high: assert property (@(posedge clk) disable iff (!reset_n)
    (m.st == M_HI && $past(m.st) == M_HI) |-> $stable(m.sda_lo)) else $error("data moved in high phase");
  chk_sda_change_low: assert property (@(posedge clk) disable iff (!reset_n)
    ($changed(m.sda_lo) && $past(m.st) == M_LO && !m.err) |-> m.scl_lo) else $error("data moved with clock released");
  chk_ack_release: assert property (@(posedge clk) disable iff (!reset_n)
    (m.st == M_HI && m.bitn == `TWI_ACK_BIT && !m.rd) |-> !m.sda_lo) else $error("data held in ack slot");
  chk_last_nack: assert property (@(posedge clk) disable iff (!reset_n)
    (m.st == M_HI && m.bitn == `TWI_ACK_BIT && m.rd && m.last) |-> !m.sda_lo) else $error("last byte acknowledged");
  chk_start_busy: assert property (@(posedge clk) disable iff (!reset_n)
    start_det |=> busy [*2]) else $error("busy not set on start");
  chk_wake_start: assert property (@(posedge clk) disable iff (!reset_n)
    (pd_mode && start_det) |=> wake ##1 !wake) else $error("wake not pulsed");
  chk_bus_err_abort: assert property (@(posedge clk) disable iff (!reset_n)
    ((m.st == M_HI || m.st == M_LO || m.st == M_REL) && (start_det || stop_det))
    |=> (m.st == M_IDLE && stat.bus_err && !scl_oe)) else $error("no abort on stray condition");
  chk_arb_lost: assert property (@(posedge clk) disable iff (!reset_n)
    (m.st == M_HI && tick && !m.rd && m.bitn != `TWI_ACK_BIT && !m.sda_lo && !sda_f && !start_det && !stop_det)
    |=> (m.st == M_IDLE && stat.arb_lost && !m.master)) else $error("arbitration loss missed");
  chk_ninth_clock: assert property (@(posedge clk) disable iff (!reset_n)
    (m.st == M_HI && tick && m.bitn == `TWI_ACK_BIT && !start_det && !stop_det) |=> m.st == M_HOLD && m.scl_lo)
    else $error("no hold after ninth clock");
  chk_slave_stretch: assert property (@(posedge clk) disable iff (!reset_n)
    (s.st == S_HOLD && !fifo_rdy && !start_det && !stop_det) |=> s.scl_lo) else $error("full buffer not stretched");
endmodule
`default_nettype wire

// File: verif/twi_slave_model.sv
// Behavioural slave device for the two-wire bus engine bench
`timescale 1ns/10ps
`default_nettype none
module twi_slave_model #(
  parameter logic [6:0] ADDR = 7'h5A,
  parameter logic [7:0] RD   = 8'hC5
) (
  // Resolved bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // Stretch request from the bench
  input  wire logic       stretch,
  // Pull-downs and received bytes
  output logic            scl_lo,
  output logic            sda_lo,
  output logic            got,
  output logic [7:0]      byte_rx
);
  logic       again;
  logic       nak;
  logic [7:0] b;
  logic [7:0] d;

  // Shift in one byte on clock rises
  task automatic get_byte();
    repeat (8) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
  endtask

  // Answer one acknowledge slot, optionally stretching the low phase
  task automatic ack_slot(input logic a);
    @(negedge scl);
    sda_lo = a;
    if (stretch) begin
      scl_lo = 1'b1;
      #8000;
      scl_lo = 1'b0;
    end
    @(negedge scl);
    sda_lo = 1'b0;
  endtask

  initial begin
    again = 1'b0;
    scl_lo = 1'b0;
    sda_lo = 1'b0;
    got = 1'b0;
  end

  // One transaction per start, cut short by stop or repeated start
  always begin
    if (!again) @(negedge sda iff scl === 1'b1);
    again = 1'b0;
    fork
      begin
        get_byte();
        ack_slot(b[7:1] == ADDR);
        if (b[7:1] == ADDR && !b[0]) begin
          forever begin
            get_byte();
            byte_rx = b;
            got = 1'b1;
            ack_slot(1'b1);
            got = 1'b0;
          end
        end else if (b[7:1] == ADDR) begin
          d = RD;
          nak = 1'b0;
          while (!nak) begin
            for (int i = 7; i >= 0; i--) begin
              sda_lo = ~d[i];
              @(negedge scl);
            end
            sda_lo = 1'b0;
            @(posedge scl);
            nak = sda;
            @(negedge scl);
            d = d + 8'h01;
          end
        end
        wait (1'b0);
      end
      @(posedge sda iff scl === 1'b1);
      begin
        @(negedge sda iff scl === 1'b1);
        again = 1'b1;
      end
    join_any
    disable fork;
    sda_lo = 1'b0;
    scl_lo = 1'b0;
    got = 1'b0;
  end
endmodule
`default_nettype wire

// File: verif/twi_engine_bench.sv
// Self-checking bench for the two-wire bus engine
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module twi_engine_bench;
  import twi_pkg::*;
  localparam logic [6:0] PADDR = 7'h5A;
  localparam logic [7:0] PRD   = 8'hC5;
  logic       clk, reset_n, b_scl_lo, b_sda_lo, cmd_valid, rx_ready, slave_en, pd_mode, m_stretch, ak;
  logic       cmd_ready, rx_valid, wake, scl_oe, sda_oe, scl_out, sda_out, m_scl_lo, m_sda_lo, m_got;
  logic [7:0] rx_data, m_byte, d;
  logic [6:0] own_addr;
  twi_cmd_s   cmd;
  twi_stat_s  stat;
  logic [7:0] exp_rx[$], exp_bus[$];
  int         error_cnt, comparisons, wake_cnt, seed, n;
  // Open-drain lines with pull-ups
  wire logic  scl = ~(scl_oe | m_scl_lo | b_scl_lo);
  wire logic  sda = ~(sda_oe | m_sda_lo | b_sda_lo);

  twi_engine uut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .own_addr(own_addr),
    .slave_en(slave_en), .pd_mode(pd_mode), .wake(wake), .stat(stat));
  twi_slave_model #(.ADDR(PADDR), .RD(PRD)) peer (.scl(scl), .sda(sda), .stretch(m_stretch),
    .scl_lo(m_scl_lo), .sda_lo(m_sda_lo), .got(m_got), .byte_rx(m_byte));

  always #5 clk = ~clk;

  // Result watchers
  always @(posedge clk) if (rx_valid === 1'b1 && rx_ready === 1'b1) `CHK("rx_data", exp_rx.pop_front(), rx_data)
  always @(posedge m_got) `CHK("bus byte", exp_bus.pop_front(), m_byte)
  always @(posedge clk) if (wake === 1'b1) wake_cnt++;

  task automatic conclude();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Command handshake, then wait for completion
  task automatic op(input twi_op_e o, input logic [7:0] dt, input logic l);
    int k;
    cmd = '{op: o, data: dt, last: l};
    cmd_valid = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 40000);
    @(negedge clk);
    cmd_valid = 1'b0;
    for (k = 0; k < 40000 && cmd_ready !== 1'b1; k++) @(negedge clk);
    if (n >= 40000 || k >= 40000) error_cnt++;
  endtask

  task automatic tick4();
    repeat (4) @(negedge clk);
  endtask

  // Bench as bus master, 160 ns bit period
  task automatic mbit(input logic bv, output logic sv);
    b_sda_lo = ~bv;
    tick4();
    b_scl_lo = 1'b0;
    for (int k = 0; k < 20000 && scl !== 1'b1; k++) @(negedge clk);
    if (scl !== 1'b1) error_cnt++;
    tick4();
    sv = sda;
    tick4();
    b_scl_lo = 1'b1;
    tick4();
  endtask

  task automatic mbyte(input logic [7:0] bv, output logic a);
    logic sv;
    for (int i = 7; i >= 0; i--) mbit(bv[i], sv);
    mbit(1'b1, sv);
    a = ~sv;
  endtask

  task automatic mstart();
    b_sda_lo = 1'b0;
    tick4();
    b_scl_lo = 1'b0;
    tick4();
    b_sda_lo = 1'b1;
    tick4();
    b_scl_lo = 1'b1;
    tick4();
  endtask

  task automatic mstop();
    b_sda_lo = 1'b1;
    tick4();
    b_scl_lo = 1'b0;
    tick4();
    b_sda_lo = 1'b0;
    tick4();
  endtask

  // Hang guard
  initial begin
    #1000000;
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    {clk, reset_n, b_scl_lo, b_sda_lo, cmd_valid, rx_ready, slave_en, m_stretch} = 8'h00;
    pd_mode = 1'b1;
    cmd = '{op: OP_STOP, data: 8'h00, last: 1'b0};
    {error_cnt, comparisons, wake_cnt} = 0;
    seed = 32'h279f;
    own_addr = {2'b01, 5'($random(seed))};
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    // Slave receiver: disabled, enabled, FIFO full, read direction
    mstart();
    mbyte({own_addr, 1'b0}, ak);
    `CHK("ack while disabled", 1'b0, ak)
    slave_en = 1'b1;
    mstart();
    mbyte({own_addr, 1'b0}, ak);
    `CHK("address ack", 1'b1, ak)
    for (int i = 0; i < 5; i++) begin
      d = 8'($random(seed));
      exp_rx.push_back(d);
      if (i < 4) mbyte(d, ak);
      else begin
        fork
          mbyte(d, ak);
          begin
            repeat (300) @(negedge clk);
            `CHK("stretch while full", 1'b0, scl)
            rx_ready = 1'b1;
          end
        join
      end
      `CHK("data ack", 1'b1, ak)
    end
    mstart();
    mbyte({own_addr, 1'b1}, ak);
    `CHK("read address ack", 1'b0, ak)
    mstop();
    pd_mode = 1'b0;
    `CHK("wake count", 3, wake_cnt)
    // Master: write with stretch, repeated start, read, stop
    d = 8'($random(seed));
    exp_bus.push_back(d);
    op(OP_START, 8'h00, 1'b0);
    `CHK("master flag", 1'b1, stat.master)
    op(OP_WRITE, {PADDR, 1'b0}, 1'b0);
    `CHK("address nack", 1'b0, stat.nack)
    m_stretch = 1'b1;
    op(OP_WRITE, d, 1'b0);
    `CHK("data nack", 1'b0, stat.nack)
    m_stretch = 1'b0;
    op(OP_START, 8'h00, 1'b0);
    `CHK("master kept", 1'b1, stat.master)
    op(OP_WRITE, {PADDR, 1'b1}, 1'b0);
    exp_rx.push_back(PRD);
    exp_rx.push_back(PRD + 8'h01);
    op(OP_READ, 8'h00, 1'b0);
    op(OP_READ, 8'h00, 1'b1);
    op(OP_STOP, 8'h00, 1'b0);
    `CHK("busy after stop", 1'b1, stat.busy)
    `CHK("master after stop", 1'b0, stat.master)
    op(OP_START, 8'h00, 1'b0);
    `CHK("bus free wait", 1'b1, n > 440 && n < 480)
    op(OP_WRITE, {~PADDR, 1'b0}, 1'b0);
    `CHK("nack unknown address", 1'b1, stat.nack)
    op(OP_STOP, 8'h00, 1'b0);
    // Stray start in a high phase aborts the transfer
    op(OP_START, 8'h00, 1'b0);
    fork
      op(OP_WRITE, 8'hFF, 1'b0);
      begin
        @(posedge scl);
        repeat (20) @(negedge clk);
        b_sda_lo = 1'b1;
      end
    join
    `CHK("bus error abort", 1'b1, stat.bus_err)
    b_sda_lo = 1'b0;
    tick4();
    // Lost arbitration: bench holds data low while engine sends ones
    op(OP_START, 8'h00, 1'b0);
    b_sda_lo = 1'b1;
    op(OP_WRITE, 8'hFF, 1'b0);
    `CHK("arbitration lost", 1'b1, stat.arb_lost)
    `CHK("slave after loss", 1'b0, stat.master)
    b_sda_lo = 1'b0;
    tick4();
    `CHK("rx drained", 0, exp_rx.size())
    `CHK("bus drained", 0, exp_bus.size())
    conclude();
  end
endmodule
`default_nettype wire
